//--- rtl/hss_config_regs.sv
`timescale 1ns/10ps
`include "hss_map.svh"
// How it works
// - bit8 zero cuts switch two on overvoltage
// - bit7 zero cuts switch one on overvoltage
// - bit6 governs overvoltage cut in stop/sleep
// - bit5 zero cuts all on undervoltage
// - bit3 restores switches after undervoltage clears
// - reserved bits always read zero
// - restart clears policy bits 15,10,4,2:0 and all selector bits
// - three 4-bit selectors at 11:8,7:4,3:0
// - codes 2,3 follow cyclic timers
// - codes 4-7 follow pulse generators
// - code 8 follows wake/sync pin
// - selectors reset to zero on every reset
// - bit9 zero cuts switch three on overvoltage
// - bits14-12 restore switches after overvoltage
// - bit11 picks overtemperature cut scope
module hss_config_regs
   import hss_pkg::*;
#(
   parameter int NUM_SWITCHES = 3
)(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        restartReq,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [6:0]  regAddr,
   input  wire logic [15:0] regWrData,
   output logic [15:0]      regRdData,
   input  wire logic        hwSrcWrEn,
   input  wire logic [11:0] hwSrcData,
   input  wire hss_mode_t   powerMode,
   input  wire logic        supplyOverVolt,
   input  wire logic        supplyUnderVolt,
   input  wire logic [2:0]  overTemp,
   input  wire logic        cyclicTimerA,
   input  wire logic        cyclicTimerB,
   input  wire logic [3:0]  pulseGen,
   input  wire logic        wakeSyncPin,
   output logic [2:0]       switchDrive,
   output logic [15:0]      policyOut,
   output logic [15:0]      sourceOut
);
   // ****************************************
   // checks
   // ****************************************
   // the selector layout and the drive pins are sized for three switches
   if (NUM_SWITCHES != 3) begin : g_bad_count
      $error("hss_config_regs serves exactly three switches");
   end

   // ****************************************
   // decode helpers
   // ****************************************
   // one address compare serves both the write and the read path
   function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] target);
      return addr == target;
   endfunction

   // reserved positions are dropped on write and again on read
   function automatic logic [15:0] keep_bits(input logic [15:0] value, input logic [15:0] mask);
      return value & mask;
   endfunction

   // normal mode has a bit per switch, low power one bit for all
   function automatic logic ov_cut(input logic fault, input logic normal, input logic ownOff,
                                   input logic lpOff);
      if (normal)
         return fault && !ownOff;
      else
         return fault && !lpOff;
   endfunction

   // ****************************************
   // input synchronisers
   // ****************************************
   // fault, timer and wake levels come from other domains; pulseGen and
   // powerMode already run on core_clk and skip the two stages
   logic [7:0] syncA_r;
   logic [7:0] syncB_r;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         syncA_r <= 8'h00;
         syncB_r <= 8'h00;
      end else begin
         syncA_r <= {supplyOverVolt, supplyUnderVolt, overTemp, cyclicTimerA, cyclicTimerB, wakeSyncPin};
         syncB_r <= syncA_r;
      end
   end
   logic       ovS;
   logic       uvS;
   logic [2:0] otS;
   logic       tmrAS;
   logic       tmrBS;
   logic       wakeS;
   // sync bit order: overvoltage, undervoltage, three sensors, timers, wake
   assign ovS   = syncB_r[7];
   assign uvS   = syncB_r[6];
   assign otS   = syncB_r[5:3];
   assign tmrAS = syncB_r[2];
   assign tmrBS = syncB_r[1];
   assign wakeS = syncB_r[0];

   // ****************************************
   // registers
   // ****************************************
   logic [15:0] policy_r;
   logic [15:0] source_r;

   // ****************************************
   // write and read decode
   // ****************************************
   // an unmapped address matches neither, so its write lands nowhere
   logic        polSel;
   logic        srcSel;
   logic        polWr;
   logic        srcWr;
   assign polSel = addr_hit(regAddr, `HSS_ADDR_POLICY);
   assign srcSel = addr_hit(regAddr, `HSS_ADDR_SOURCE);
   assign polWr  = regWrEn && polSel;
   assign srcWr  = regWrEn && srcSel;

   // restart keeps the configuration fields and drops the reserved ones
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         policy_r <= `HSS_POL_RESET;
      else if (restartReq)
         policy_r <= keep_bits(policy_r, `HSS_POL_RESTART_KEEP);
      else if (polWr)
         policy_r <= keep_bits(regWrData, `HSS_POL_WMASK);
   end

   // hardware update wins over a software write in the same cycle
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         source_r <= `HSS_SRC_RESET;
      else if (restartReq)
         source_r <= `HSS_SRC_RESET;
      else if (hwSrcWrEn)
         source_r <= {4'h0, hwSrcData};
      else if (srcWr)
         source_r <= keep_bits(regWrData, `HSS_SRC_WMASK);
   end

   // read data is registered and holds until the next read strobe
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         regRdData <= 16'h0000;
      else if (regRdEn) begin
         if (polSel)
            regRdData <= keep_bits(policy_r, `HSS_POL_WMASK);
         else if (srcSel)
            regRdData <= keep_bits(source_r, `HSS_SRC_WMASK);
         else
            regRdData <= 16'h0000;
      end
   end

   // ****************************************
   // register copies
   // ****************************************
   // copies lag the registers by one cycle so they come straight from flops
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         policyOut <= 16'h0000;
         sourceOut <= 16'h0000;
      end else begin
         policyOut <= policy_r;
         sourceOut <= source_r;
      end
   end

   // ****************************************
   // shutdown policy
   // ****************************************
   logic       normalMode;
   logic       lpOvOff;
   logic [2:0] ovCut;
   logic [2:0] ovRestore;
   // a policy change while a fault stands acts at once, not at the next fault edge
   assign normalMode = (powerMode == HSS_MODE_NORMAL);
   assign lpOvOff    = policy_r[`HSS_POL_LP_OV_OFF];
   assign ovCut[0] = ov_cut(ovS, normalMode, policy_r[`HSS_POL_OV1_OFF], lpOvOff);
   assign ovCut[1] = ov_cut(ovS, normalMode, policy_r[`HSS_POL_OV2_OFF], lpOvOff);
   assign ovCut[2] = ov_cut(ovS, normalMode, policy_r[`HSS_POL_OV3_OFF], lpOvOff);
   // restore bits travel as one vector, switch one at bit 0
   assign ovRestore = {policy_r[`HSS_POL_REC3], policy_r[`HSS_POL_REC2], policy_r[`HSS_POL_REC1]};

   // ****************************************
   // undervoltage and overtemperature
   // ****************************************
   logic       uvCut;
   logic       uvRestore;
   logic       otAny;
   logic [2:0] otCut;
   assign uvCut     = uvS && !policy_r[`HSS_POL_UV_OFF];
   assign uvRestore = policy_r[`HSS_POL_UV_REST];
   assign otAny     = |otS;
   // all scope ORs the sensors; individual scope gives each switch its own
   assign otCut     = policy_r[`HSS_POL_OT_SCOPE] ? otS : {3{otAny}};

   // ****************************************
   // switch outputs
   // ****************************************
   // reserved selector codes drive off if software writes them anyway
   // each gate owns its edge detectors and fault latches
   for (genvar i = 0; i < NUM_SWITCHES; i++) begin : g_sw
      hss_switch_gate u_gate (
         .core_clk  (core_clk),
         .reset     (reset),
         .sourceSel (source_r[4*i +: 4]),
         .tmrA      (tmrAS),
         .tmrB      (tmrBS),
         .pwmGen    (pulseGen),
         .wakeSync  (wakeS),
         .cutOv     (ovCut[i]),
         .restoreOv (ovRestore[i]),
         .cutUv     (uvCut),
         .restoreUv (uvRestore),
         .cutOt     (otCut[i]),
         .drive     (switchDrive[i])
      );
   end
endmodule // hss_config_regs

//--- rtl/hss_map.svh
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH
// register addresses on the serial register port (7-bit)
`define HSS_ADDR_POLICY        7'h07
`define HSS_ADDR_SOURCE        7'h08
// shutdown-policy field positions
`define HSS_POL_REC3           14
`define HSS_POL_REC2           13
`define HSS_POL_REC1           12
`define HSS_POL_OT_SCOPE       11
`define HSS_POL_OV3_OFF        9
`define HSS_POL_OV2_OFF        8
`define HSS_POL_OV1_OFF        7
`define HSS_POL_LP_OV_OFF      6
`define HSS_POL_UV_OFF         5
`define HSS_POL_UV_REST        3
// writable masks and reset values
`define HSS_POL_WMASK          16'h7be8
`define HSS_POL_RESTART_KEEP   16'h7be8
`define HSS_SRC_WMASK          16'h0fff
`define HSS_POL_RESET          16'h0000
`define HSS_SRC_RESET          16'h0000
`endif

//--- rtl/hss_pkg.sv
package hss_pkg;
   typedef enum logic [3:0] {
      HSS_SRC_OFF    = 4'h0,
      HSS_SRC_ON     = 4'h1,
      HSS_SRC_TMR_A  = 4'h2,
      HSS_SRC_TMR_B  = 4'h3,
      HSS_SRC_PWM1   = 4'h4,
      HSS_SRC_PWM2   = 4'h5,
      HSS_SRC_PWM3   = 4'h6,
      HSS_SRC_PWM4   = 4'h7,
      HSS_SRC_WAKE   = 4'h8
   } hss_source_t;
   typedef enum logic [1:0] {
      HSS_MODE_NORMAL = 2'h0,
      HSS_MODE_STOP   = 2'h1,
      HSS_MODE_SLEEP  = 2'h2
   } hss_mode_t;
endpackage

//--- rtl/hss_switch_gate.sv
`timescale 1ns/10ps
// one switch: source mux plus overvoltage and undervoltage shutdown and restore latches
module hss_switch_gate
   import hss_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [3:0] sourceSel,
   input  wire logic       tmrA,
   input  wire logic       tmrB,
   input  wire logic [3:0] pwmGen,
   input  wire logic       wakeSync,
   input  wire logic       cutOv,
   input  wire logic       restoreOv,
   input  wire logic       cutUv,
   input  wire logic       restoreUv,
   input  wire logic       cutOt,
   output logic            drive
);
   logic srcLevel;
   logic ovLatched_r;
   logic uvLatched_r;
   logic cutOvD_r;
   logic cutUvD_r;

   always_comb begin
      unique case (sourceSel)
         HSS_SRC_OFF:   srcLevel = 1'b0;
         HSS_SRC_ON:    srcLevel = 1'b1;
         HSS_SRC_TMR_A: srcLevel = tmrA;
         HSS_SRC_TMR_B: srcLevel = tmrB;
         HSS_SRC_PWM1:  srcLevel = pwmGen[0];
         HSS_SRC_PWM2:  srcLevel = pwmGen[1];
         HSS_SRC_PWM3:  srcLevel = pwmGen[2];
         HSS_SRC_PWM4:  srcLevel = pwmGen[3];
         HSS_SRC_WAKE:  srcLevel = wakeSync;
         // reserved codes: safest answer is off
         default:       srcLevel = 1'b0;
      endcase
   end

   // latch stays off after the fault unless restore is set or the selector goes to the off code
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ovLatched_r <= 1'b0;
         cutOvD_r    <= 1'b0;
      end else begin
         cutOvD_r <= cutOv;
         if (cutOv && !cutOvD_r)
            ovLatched_r <= 1'b1;
         else if (!cutOv && cutOvD_r && restoreOv)
            ovLatched_r <= 1'b0;
         else if (sourceSel == HSS_SRC_OFF)
            ovLatched_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         uvLatched_r <= 1'b0;
         cutUvD_r    <= 1'b0;
      end else begin
         cutUvD_r <= cutUv;
         if (cutUv && !cutUvD_r)
            uvLatched_r <= 1'b1;
         else if (!cutUv && cutUvD_r && restoreUv)
            uvLatched_r <= 1'b0;
         else if (sourceSel == HSS_SRC_OFF)
            uvLatched_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         drive <= 1'b0;
      else
         drive <= srcLevel && !cutOv && !cutUv && !cutOt && !ovLatched_r && !uvLatched_r;
   end
endmodule // hss_switch_gate

//--- testbench/hss_config_regs_sva.sv
`timescale 1ns/10ps
module hss_config_regs_sva (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        restartReq,
   input wire logic        regWrEn,
   input wire logic        regRdEn,
   input wire logic [6:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData,
   input wire logic        hwSrcWrEn,
   input wire logic [11:0] hwSrcData,
   input wire logic [2:0]  switchDrive,
   input wire logic [15:0] policyOut,
   input wire logic [15:0] sourceOut
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // ****************
   // register and switch checks
   // ****************
   sequence polRd; regRdEn && regAddr == 7'h07; endsequence
   sequence nowhereRd; regRdEn && regAddr != 7'h07 && regAddr != 7'h08; endsequence
   sequence srcOff; (sourceOut[3:0] == 4'h0) [*2]; endsequence
   pol_resv_zero_a: assert property ((policyOut & 16'h8417) == 16'h0000)
      else $error("policy reserved bit set");
   src_resv_zero_a: assert property (sourceOut[15:12] == 4'h0)
      else $error("source reserved bit set");
   pol_read_a: assert property (polRd |=> (regRdData & 16'h8417) == 16'h0000)
      else $error("policy read shows reserved bit");
   unmapped_read_a: assert property (nowhereRd |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   restart_keep_a: assert property (restartReq |=> ##1 policyOut == ($past(policyOut) & 16'h7be8))
      else $error("restart changed kept policy fields");
   restart_src_a: assert property (restartReq |=> ##1 sourceOut == 16'h0000)
      else $error("restart left selectors set");
   pol_write_a: assert property (regWrEn && regAddr == 7'h07 && !restartReq
      |=> ##1 policyOut == ($past(regWrData, 2) & 16'h7be8))
      else $error("policy write wrong");
   src_write_a: assert property (regWrEn && regAddr == 7'h08 && !restartReq && !hwSrcWrEn
      |=> ##1 sourceOut == ($past(regWrData, 2) & 16'h0fff))
      else $error("selector write wrong");
   hw_src_a: assert property (hwSrcWrEn && !restartReq |=> ##1 sourceOut == {4'h0, $past(hwSrcData, 2)})
      else $error("hardware selector update wrong");
   off_code_a: assert property (srcOff |-> !switchDrive[0])
      else $error("switch on with off code");
endmodule // hss_config_regs_sva
bind hss_config_regs hss_config_regs_sva u_sva (.core_clk, .reset, .restartReq, .regWrEn, .regRdEn, .regAddr,
   .regWrData, .regRdData, .hwSrcWrEn, .hwSrcData, .switchDrive, .policyOut, .sourceOut);

//--- testbench/hss_source_model.sv
`timescale 1ns/10ps
// ****************
// steady control sources; flip inverts all, so each code from 2 up is seen both ways
// ****************
module hss_source_model (
   input  wire logic flip,
   output logic       cyclicTimerA,
   output logic       cyclicTimerB,
   output logic [3:0] pulseGen,
   output logic       wakeSyncPin
);
   assign cyclicTimerA = ~flip;
   assign cyclicTimerB = flip;
   assign pulseGen     = 4'ha ^ {4{flip}};
   assign wakeSyncPin  = ~flip;
endmodule // hss_source_model

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb;
   import hss_pkg::*;
   logic        core_clk = 1'b0, reset = 1'b1, restartReq = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
   logic [6:0]  regAddr = 7'h00;
   logic [15:0] regWrData = 16'h0000, regRdData, policyOut, sourceOut;
   logic        hwSrcWrEn = 1'b0, supplyOverVolt = 1'b0, supplyUnderVolt = 1'b0, flip = 1'b0;
   logic [11:0] hwSrcData = 12'h000;
   logic [2:0]  overTemp = 3'h0, switchDrive;
   hss_mode_t   powerMode = HSS_MODE_NORMAL;
   logic        cyclicTimerA, cyclicTimerB, wakeSyncPin;
   logic [3:0]  pulseGen;
   int          error_cnt = 0, cmp_count = 0;
   hss_config_regs DUT (.core_clk, .reset, .restartReq, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
      .hwSrcWrEn, .hwSrcData, .powerMode, .supplyOverVolt, .supplyUnderVolt, .overTemp, .cyclicTimerA,
      .cyclicTimerB, .pulseGen, .wakeSyncPin, .switchDrive, .policyOut, .sourceOut);
   hss_source_model src (.flip, .cyclicTimerA, .cyclicTimerB, .pulseGen, .wakeSyncPin);
   initial forever #4 core_clk = ~core_clk;
   // ****************
   // shared tasks
   // ****************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge core_clk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge core_clk);
      regWrEn = 1'b0;
   endtask
   task rd(input logic [6:0] a, output logic [15:0] d);
      @(negedge core_clk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge core_clk);
      regRdEn = 1'b0;
      d = regRdData;
   endtask
   task summarize;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task t_regs;
      logic [15:0] d;
      rd(7'h07, d);
      chk(d, 16'h0000);
      rd(7'h08, d);
      chk(d, 16'h0000);
      wr(7'h07, 16'hffff);
      rd(7'h07, d);
      chk(d, 16'h7be8);
      wr(7'h08, 16'hf888);
      rd(7'h08, d);
      chk(d, 16'h0888);
      wr(7'h15, 16'hffff);
      rd(7'h15, d);
      chk(d, 16'h0000);
      @(negedge core_clk);
      restartReq = 1'b1;
      @(negedge core_clk);
      restartReq = 1'b0;
      rd(7'h07, d);
      chk(d, 16'h7be8);
      rd(7'h08, d);
      chk(d, 16'h0000);
      // a second power-on reset mid-run must clear what restart kept
      wr(7'h08, 16'h0111);
      wt(4);
      chk(16'(switchDrive), 16'h0007);
      reset = 1'b1;
      wt(2);
      chk(16'(switchDrive), 16'h0000);
      reset = 1'b0;
      rd(7'h07, d);
      chk(d, 16'h0000);
      rd(7'h08, d);
      chk(d, 16'h0000);
      $display("test regs done");
   endtask
   task t_src;
      logic [8:0] tbl;
      tbl = 9'h1a6;
      for (int f = 0; f < 2; f++) begin
         flip = f[0];
         // only defined codes; reserved ones stay unwritten
         for (int c = 0; c < 9; c++) begin
            wr(7'h08, 16'h0111 * 16'(c));
            wt(5);
            chk(16'(switchDrive), 16'({3{tbl[c] ^ (f[0] & (c > 1))}}));
         end
      end
      flip = 1'b0;
      // hardware update and software write in one cycle: hardware wins
      @(negedge core_clk);
      hwSrcWrEn = 1'b1;
      hwSrcData = 12'h180;
      regWrEn = 1'b1;
      regAddr = 7'h08;
      regWrData = 16'h0001;
      @(negedge core_clk);
      hwSrcWrEn = 1'b0;
      regWrEn = 1'b0;
      wt(5);
      chk(16'(switchDrive), 16'h0006);
      $display("test sources done");
   endtask
   task t_fault;
      // fault kind (0 over, 1 under, 2 temp), mode, policy, drive during, drive after
      logic [25:0] rows [13];
      rows = '{{2'd0, 2'd0, 16'h0000, 3'h0, 3'h0}, {2'd0, 2'd0, 16'h0380, 3'h7, 3'h7},
               {2'd0, 2'd0, 16'h0100, 3'h2, 3'h2}, {2'd0, 2'd1, 16'h0380, 3'h0, 3'h0},
               {2'd0, 2'd1, 16'h0040, 3'h7, 3'h7}, {2'd0, 2'd0, 16'h5000, 3'h0, 3'h5},
               {2'd1, 2'd0, 16'h0000, 3'h0, 3'h0}, {2'd1, 2'd0, 16'h0020, 3'h7, 3'h7},
               {2'd1, 2'd0, 16'h0008, 3'h0, 3'h7}, {2'd0, 2'd2, 16'h0380, 3'h0, 3'h0},
               {2'd0, 2'd2, 16'h0040, 3'h7, 3'h7}, {2'd2, 2'd0, 16'h0000, 3'h0, 3'h7},
               {2'd2, 2'd0, 16'h0800, 3'h5, 3'h7}};
      for (int i = 0; i < 13; i++) begin
         wr(7'h07, rows[i][21:6]);
         powerMode = hss_mode_t'(rows[i][23:22]);
         wr(7'h08, 16'h0000);
         wr(7'h08, 16'h0111);
         wt(5);
         supplyOverVolt = (rows[i][25:24] == 2'd0);
         supplyUnderVolt = (rows[i][25:24] == 2'd1);
         overTemp = (rows[i][25:24] == 2'd2) ? 3'h2 : 3'h0;
         wt(6);
         chk(16'(switchDrive), 16'(rows[i][5:3]));
         supplyOverVolt = 1'b0;
         supplyUnderVolt = 1'b0;
         overTemp = 3'h0;
         wt(6);
         chk(16'(switchDrive), 16'(rows[i][2:0]));
      end
      powerMode = HSS_MODE_NORMAL;
      $display("test faults done");
   endtask
   initial begin
      wt(20);
      reset = 1'b0;
      t_regs;
      t_src;
      t_fault;
      summarize;
   end
   // tests need under a thousand cycles; this allows over ten times that
   initial begin
      #100000;
      error_cnt++;
      summarize;
   end
endmodule // tb
